/* File: dsc_pkg.sv */
// Constants and types shared by the dual-source charge control block
package dsc_pkg;
	// ----------------------------------------
	// Clock and timer lengths
	// ----------------------------------------
	localparam longint unsigned CLK_HZ = 200_000_000;
	localparam longint unsigned UNATT_S = 900;
	localparam longint unsigned WDOG_S = 32;
	localparam longint unsigned UNATT_CYC = UNATT_S * CLK_HZ;
	localparam longint unsigned WDOG_CYC = WDOG_S * CLK_HZ;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] BUS_BASE = 8'h00;
	localparam logic [7:0] AUX_BASE = 8'h40;
	localparam logic [7:0] IRQ_STAT_ADR = 8'h80;
	localparam logic [7:0] IRQ_MASK_ADR = 8'h84;
	localparam logic [7:0] STATE_ADR = 8'h88;
	localparam int NREG = 6;
	localparam logic [2:0] REG_STAT = 3'h0;
	localparam logic [2:0] REG_CTL = 3'h1;
	localparam logic [2:0] REG_VF = 3'h2;
	localparam logic [2:0] REG_ID = 3'h3;
	localparam logic [2:0] REG_CHARGE_CURRENT_CODE = 3'h4;
	localparam logic [2:0] REG_LIM = 3'h5;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int KICK_BIT = 1;
	localparam int FAULT_LSB = 0;
	localparam int BUSLIM_LSB = 6;
	localparam int TE_BIT = 3;
	localparam int CE_BIT = 2;
	localparam int HZ_BIT = 1;
	localparam int VF_LSB = 2;
	localparam int RST_BIT = 7;
	localparam int AUX_CHARGE_CURRENT_CODE_LSB = 3;
	localparam int BUS_CHARGE_CURRENT_CODE_LSB = 4;
	localparam int TERMINATION_CURRENT_CODE_LSB = 0;
	localparam int LOWI_BIT = 5;
	localparam int SP_BIT = 4;
	localparam int SAG_LSB = 0;
	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] VF_RST = 8'h08;
	localparam logic [7:0] CHARGE_CURRENT_CODE_RST = 8'h00;
	localparam logic [7:0] LIM_RST = 8'h20;
	localparam logic [7:0] CHIP_ID = 8'h5a; // Arbitrary value
	localparam logic [3:0] AUX_CHARGE_CURRENT_CODE_MAX = 4'ha;
	localparam logic [2:0] FAULT_TIMER = 3'h6;
	localparam logic [5:0] VF_CODE_MAX = 6'h2f;
	localparam logic [12:0] VF_BASE_MV = 13'hdac;
	localparam logic [12:0] VF_STEP_MV = 13'h014;
	// ----------------------------------------
	// Interrupt bits
	// ----------------------------------------
	localparam int IRQ_W = 5;
	localparam int IRQ_SRC = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_WDOG = 3;
	localparam int IRQ_UNATT = 4;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {SRC_NONE, SRC_BUS, SRC_AUX} dsc_src_t;
	typedef enum logic [2:0] {PH_IDLE, PH_PRE, PH_CC, PH_CV, PH_DONE} dsc_phase_t;
endpackage

/* File: dsc_charge_ctrl.sv */
// Dual-source charge control: source select, register banks, timers, phases
//
// Operation
// - Auxiliary input wins when valid; bus input only if aux invalid and bus valid.
// - Bus charging moves to the auxiliary input when it becomes valid.
// - Aux valid during bus charge with aux high-impedance set stops charging.
// - Unattended timer expiry with both inputs present sets both charge-disable bits.
// - Weak battery restart needs both inputs gone, then one valid input.
// - Faults recorded in the active source's bank status; in the bus bank when no source is selected.
// - Watchdog expiry resets active bank only, flags timer fault, goes unattended.
// - Pre-charge below short threshold, then constant-current above it.
// - Voltage phase ends at termination current, only when termination enabled.
// - Termination enable is REG1 bit 3; termination code is REG4 bits 2:0.
// - Bus bank at one address, aux bank at another; each used with its source.
// - Float code REG2[7:2]; aux current REG4[6:3]; bus current REG4[6:4].
// - Float voltage 3.5 V plus 20 mV per step, saturating at 4.44 V.
// - New cycle on recharge drop, weak-battery connect, or disable bits cleared.
// - Low-current default bit REG5[5], set at reset, forces 325 mA limit.
// - Aux current code writes above 10 store 10.
// - Sag voltage code REG5[2:0] limits draw on either selected source.
// - Bus input limit REG1[7:6] applies to bus charging only.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module dsc_charge_ctrl
	import dsc_pkg::*;
#(
	parameter logic [39:0] UNATT_CYCLES = 40'(UNATT_CYC),
	parameter logic [39:0] WDOG_CYCLES = 40'(WDOG_CYC)
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Analog status pins
	input wire logic aux_valid_i,
	input wire logic bus_valid_i,
	input wire logic bat_below_short_i,
	input wire logic bat_below_weak_i,
	input wire logic bat_below_recharge_i,
	input wire logic bat_at_float_i,
	input wire logic term_current_i,
	input wire logic sag_active_i,
	input wire logic boost_on_i,
	input wire logic fault_i,
	input wire logic [2:0] fault_code_i,
	// Charger controls
	output logic [1:0] selected_charge_source_o,
	output logic precharge_o,
	output logic switcher_on_o,
	output logic [2:0] phase_o,
	output logic [12:0] float_mv_o,
	output logic [3:0] charge_current_code_o,
	output logic low_current_limit_o,
	output logic bus_limit_en_o,
	output logic [1:0] bus_input_limit_code_o,
	output logic [2:0] sag_voltage_code_o,
	output logic [2:0] termination_current_code_o,
	output logic unattended_o,
	output logic irq_o
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [7:0] bank_default(input int idx);
		case (idx)
			0: bank_default = STAT_RST;
			1: bank_default = CTL_RST;
			2: bank_default = VF_RST;
			4: bank_default = CHARGE_CURRENT_CODE_RST;
			5: bank_default = LIM_RST;
			default: bank_default = 8'h00;
		endcase
	endfunction

	function automatic logic [12:0] float_mv(input logic [5:0] code);
		logic [5:0] c;
		c = (code > VF_CODE_MAX) ? VF_CODE_MAX : code;
		float_mv = VF_BASE_MV + 13'(c * VF_STEP_MV);
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NS = 13;
	logic [NS-1:0] sync1_q;
	logic [NS-1:0] sync2_q;
	logic aux_v, bus_v, b_short, b_weak, b_rch, b_float, b_term;
	logic sag_v, boost_v, fault_v;
	logic [2:0] fcode_v;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {fault_code_i, fault_i, boost_on_i, sag_active_i, term_current_i,
				bat_at_float_i, bat_below_recharge_i, bat_below_weak_i,
				bat_below_short_i, bus_valid_i, aux_valid_i};
			sync2_q <= sync1_q;
		end
	end
	assign {fcode_v, fault_v, boost_v, sag_v, b_term, b_float, b_rch, b_weak,
		b_short, bus_v, aux_v} = sync2_q;

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	dsc_src_t src_q, src_d;
	assign src_d = aux_v ? SRC_AUX : (bus_v ? SRC_BUS : SRC_NONE);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_q <= SRC_NONE;
		end else begin
			src_q <= src_d;
		end
	end
	wire act = (src_q == SRC_AUX);
	wire src_chg = (src_q != src_d);
	wire por = (src_q == SRC_NONE) && (src_d != SRC_NONE);
	wire por_weak = por && b_weak;

	// ----------------------------------------
	// Wishbone decode
	// ----------------------------------------
	logic ack_q;
	wire req = wb_cyc_i && wb_stb_i && !ack_q;
	wire wr = req && wb_we_i && wb_sel_i[0];
	wire in_bus = (wb_adr_i[7:5] == BUS_BASE[7:5]) && (wb_adr_i[4:2] < 3'(NREG));
	wire in_aux = (wb_adr_i[7:5] == AUX_BASE[7:5]) && (wb_adr_i[4:2] < 3'(NREG));
	wire wbank = in_aux;
	wire [2:0] widx = wb_adr_i[4:2];
	wire bank_wr = wr && (in_bus || in_aux);
	wire [7:0] wdat = wb_dat_i[7:0];
	wire kick = bank_wr && (widx == REG_STAT) && wdat[KICK_BIT];
	wire host_rst = bank_wr && (widx == REG_CHARGE_CURRENT_CODE) && wdat[RST_BIT];

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	logic unatt_q;
	logic [39:0] t15_q;
	logic [39:0] t32_q;
	dsc_phase_t ph_q, ph_d;
	wire charging = (ph_q != PH_IDLE) && (ph_q != PH_DONE);
	wire t15_exp = unatt_q && charging && (t15_q == UNATT_CYCLES - 40'h1);
	wire t32_exp = !unatt_q && (t32_q == WDOG_CYCLES - 40'h1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unatt_q <= 1'b1;
			t15_q <= '0;
			t32_q <= '0;
		end else begin
			if (t32_exp || por_weak || host_rst) begin
				unatt_q <= 1'b1;
				t15_q <= '0;
			end else if (bank_wr) begin
				unatt_q <= 1'b0;
			end else if (unatt_q && charging && !t15_exp) begin
				t15_q <= t15_q + 40'h1;
			end
			if (bank_wr || kick || t32_exp || unatt_q) begin
				t32_q <= '0;
			end else begin
				t32_q <= t32_q + 40'h1;
			end
		end
	end

	// ----------------------------------------
	// Register banks
	// ----------------------------------------
	logic [7:0] bank_q [2][NREG];
	wire [7:0] act_ctl = bank_q[act][REG_CTL];
	wire [7:0] act_vf = bank_q[act][REG_VF];
	wire [7:0] act_charge_current_code = bank_q[act][REG_CHARGE_CURRENT_CODE];
	wire [7:0] act_lim = bank_q[act][REG_LIM];
	logic fault_q;
	wire fault_ev = fault_v && !fault_q && (charging || boost_v);
	wire fbank = (src_q == SRC_NONE) ? 1'b0 : act;
	wire [3:0] aux_charge_current_code_w = wdat[AUX_CHARGE_CURRENT_CODE_LSB +: 4];
	wire [3:0] aux_charge_current_code_c = (aux_charge_current_code_w > AUX_CHARGE_CURRENT_CODE_MAX) ? AUX_CHARGE_CURRENT_CODE_MAX : aux_charge_current_code_w;
	logic [7:0] wval;
	always_comb begin
		wval = wdat;
		if (widx == REG_CHARGE_CURRENT_CODE) begin
			wval[RST_BIT] = 1'b0;
			if (wbank) begin
				wval[AUX_CHARGE_CURRENT_CODE_LSB +: 4] = aux_charge_current_code_c;
			end else begin
				wval[AUX_CHARGE_CURRENT_CODE_LSB] = 1'b0;
			end
		end
		if (widx == REG_LIM) begin
			wval[SP_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < NREG; i++) begin
					bank_q[b][i] <= bank_default(i);
				end
			end
		end else begin
			if (bank_wr && widx != REG_STAT && widx != REG_ID) begin
				bank_q[wbank][widx] <= wval;
			end
			if (host_rst) begin
				for (int i = 0; i < NREG; i++) begin
					bank_q[wbank][i] <= bank_default(i);
				end
			end
			if (por_weak) begin
				for (int b = 0; b < 2; b++) begin
					for (int i = 0; i < NREG; i++) begin
						bank_q[b][i] <= bank_default(i);
					end
				end
			end
			if (t32_exp) begin
				for (int i = 0; i < NREG; i++) begin
					bank_q[act][i] <= bank_default(i);
				end
				bank_q[act][REG_STAT][FAULT_LSB +: 3] <= FAULT_TIMER;
			end
			if (t15_exp) begin
				bank_q[act][REG_STAT][FAULT_LSB +: 3] <= FAULT_TIMER;
				if (bus_v) begin
					bank_q[0][REG_CTL][CE_BIT] <= 1'b1;
				end
				if (aux_v) begin
					bank_q[1][REG_CTL][CE_BIT] <= 1'b1;
				end
			end
			if (fault_ev) begin
				bank_q[fbank][REG_STAT][FAULT_LSB +: 3] <= fcode_v;
			end
		end
	end

	// ----------------------------------------
	// Charge start events
	// ----------------------------------------
	logic [1:0] blk_q;
	wire [1:0] blk;
	assign blk[0] = bank_q[0][REG_CTL][CE_BIT] || bank_q[0][REG_CTL][HZ_BIT];
	assign blk[1] = bank_q[1][REG_CTL][CE_BIT] || bank_q[1][REG_CTL][HZ_BIT];
	wire unblock = blk_q[act] && !blk[act] && (src_q != SRC_NONE);
	wire nxt_act = (src_d == SRC_AUX);
	wire can_charge = (src_d != SRC_NONE) && (!blk[nxt_act] || por_weak);
	wire start = por_weak || unblock;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blk_q <= 2'b00;
			fault_q <= 1'b0;
		end else begin
			blk_q <= blk;
			fault_q <= fault_v;
		end
	end

	// ----------------------------------------
	// Charge phase sequencer
	// ----------------------------------------
	wire te = act_ctl[TE_BIT];
	always_comb begin
		ph_d = ph_q;
		case (ph_q)
			PH_IDLE: begin
				if (start && can_charge) begin
					ph_d = b_short ? PH_PRE : PH_CC;
				end
			end
			PH_PRE: begin
				if (!b_short) begin
					ph_d = PH_CC;
				end
			end
			PH_CC: begin
				if (b_float) begin
					ph_d = PH_CV;
				end
			end
			PH_CV: begin
				if (te && b_term) begin
					ph_d = PH_DONE;
				end
			end
			PH_DONE: begin
				if (b_rch) begin
					ph_d = b_short ? PH_PRE : PH_CC;
				end
			end
			default: ph_d = PH_IDLE;
		endcase
		if (!can_charge || t15_exp) begin
			ph_d = PH_IDLE;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_q <= PH_IDLE;
		end else begin
			ph_q <= ph_d;
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	logic [IRQ_W-1:0] istat_q;
	logic [IRQ_W-1:0] imask_q;
	logic [IRQ_W-1:0] iev;
	assign iev[IRQ_SRC] = src_chg;
	assign iev[IRQ_DONE] = (ph_q == PH_CV) && (ph_d == PH_DONE);
	assign iev[IRQ_FAULT] = fault_ev;
	assign iev[IRQ_WDOG] = t32_exp;
	assign iev[IRQ_UNATT] = t15_exp;
	wire istat_wr = wr && (wb_adr_i == IRQ_STAT_ADR);
	wire imask_wr = wr && (wb_adr_i == IRQ_MASK_ADR);
	wire [IRQ_W-1:0] iclr = istat_wr ? wb_dat_i[IRQ_W-1:0] : '0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			istat_q <= '0;
			imask_q <= '0;
		end else begin
			istat_q <= (istat_q & ~iclr) | iev;
			if (imask_wr) begin
				imask_q <= wb_dat_i[IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	wire [7:0] rreg = bank_q[wbank][widx];
	logic [7:0] bank_rd;
	always_comb begin
		bank_rd = rreg;
		if (widx == REG_ID) begin
			bank_rd = CHIP_ID;
		end
		if (widx == REG_LIM) begin
			bank_rd[SP_BIT] = sag_v && (act == wbank) && (src_q != SRC_NONE);
		end
	end
	logic [31:0] rdat;
	always_comb begin
		rdat = 32'h0;
		if (in_bus || in_aux) begin
			rdat = {24'h0, bank_rd};
		end else if (wb_adr_i == IRQ_STAT_ADR) begin
			rdat = {27'h0, istat_q};
		end else if (wb_adr_i == IRQ_MASK_ADR) begin
			rdat = {27'h0, imask_q};
		end else if (wb_adr_i == STATE_ADR) begin
			rdat = {24'h0, unatt_q, ph_q, 1'b0, src_q, 1'b0};
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			ack_q <= req;
			wb_dat_o <= req ? rdat : 32'h0;
		end
	end
	assign wb_ack_o = ack_q;

	// ----------------------------------------
	// Charger control outputs
	// ----------------------------------------
	wire lowi = act_lim[LOWI_BIT];
	wire [3:0] charge_current_code = act ? act_charge_current_code[AUX_CHARGE_CURRENT_CODE_LSB +: 4] : {1'b0, act_charge_current_code[BUS_CHARGE_CURRENT_CODE_LSB +: 3]};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			selected_charge_source_o <= 2'b00;
			precharge_o <= 1'b0;
			switcher_on_o <= 1'b0;
			phase_o <= 3'h0;
			float_mv_o <= VF_BASE_MV;
			charge_current_code_o <= 4'h0;
			low_current_limit_o <= 1'b1;
			bus_limit_en_o <= 1'b0;
			bus_input_limit_code_o <= 2'b00;
			sag_voltage_code_o <= 3'h0;
			termination_current_code_o <= 3'h0;
			unattended_o <= 1'b1;
			irq_o <= 1'b0;
		end else begin
			selected_charge_source_o <= src_q;
			precharge_o <= (ph_q == PH_PRE);
			switcher_on_o <= (ph_q == PH_CC) || (ph_q == PH_CV);
			phase_o <= ph_q;
			float_mv_o <= float_mv(act_vf[VF_LSB +: 6]);
			charge_current_code_o <= lowi ? 4'h0 : charge_current_code;
			low_current_limit_o <= lowi;
			bus_limit_en_o <= (src_q == SRC_BUS);
			bus_input_limit_code_o <= bank_q[0][REG_CTL][BUSLIM_LSB +: 2];
			sag_voltage_code_o <= act_lim[SAG_LSB +: 3];
			termination_current_code_o <= act_charge_current_code[TERMINATION_CURRENT_CODE_LSB +: 3];
			unattended_o <= unatt_q;
			irq_o <= |(istat_q & imask_q);
		end
	end
endmodule

/* File: dsc_charge_ctrl_asserts.sv */
// Port assertions for the charge control block
`timescale 1ns/1ps
module dsc_charge_ctrl_asserts (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Sources and charger controls
	input wire logic aux_valid_i,
	input wire logic bus_valid_i,
	input wire logic [1:0] selected_charge_source_o,
	input wire logic precharge_o,
	input wire logic switcher_on_o,
	input wire logic [2:0] phase_o,
	input wire logic [12:0] float_mv_o,
	input wire logic [3:0] charge_current_code_o,
	input wire logic low_current_limit_o,
	input wire logic bus_limit_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answers: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack missing");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_aux_wins: assert property (aux_valid_i [*5] |-> selected_charge_source_o == 2'h2)
		else $error("aux not selected");
	a_bus_fallback: assert property ((!aux_valid_i && bus_valid_i) [*5]
		|-> selected_charge_source_o == 2'h1) else $error("bus not selected");
	a_no_source: assert property ((!aux_valid_i && !bus_valid_i) [*5]
		|-> selected_charge_source_o == 2'h0) else $error("source without input");
	a_buslim_aux_off: assert property ((selected_charge_source_o == 2'h2) [*2]
		|-> !bus_limit_en_o) else $error("bus limit on aux");
	a_float_range: assert property (float_mv_o >= 13'hdac && float_mv_o <= 13'h1158
		&& (float_mv_o - 13'hdac) % 13'h014 == 13'h0) else $error("float voltage off grid");
	a_lowi_code: assert property (low_current_limit_o |-> charge_current_code_o == 4'h0)
		else $error("current code not ignored");
	a_pre_linear: assert property (precharge_o |-> phase_o == 3'h1 && !switcher_on_o)
		else $error("precharge with switcher");
	a_sw_phase: assert property (switcher_on_o |-> phase_o inside {3'h2, 3'h3})
		else $error("switcher outside cc or cv");
endmodule

/* File: dsc_host_model.sv */
// Wishbone classic host standing in for the system processor
`timescale 1ns/1ps
module dsc_host_model (
	// Clock
	input wire logic clk_i,
	// Wishbone master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i
);
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
	end
	// One cycle, held until ack is sampled, then one idle cycle
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= wr;
		wb_adr_o <= a;
		wb_sel_o <= 4'h1;
		wb_dat_o <= {24'h0, d};
		do begin
			@(posedge clk_i);
		end while (wb_ack_i !== 1'b1);
		q = wb_dat_i[7:0];
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

/* File: dsc_charge_ctrl_bench.sv */
// Self-checking bench for the charge control block
`timescale 1ns/1ps
module dsc_charge_ctrl_bench;
	import dsc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, pre, sw, lowi, blen, unatt, irq, qa;
	logic [7:0] adr, q;
	logic [3:0] sel, ccc;
	logic [31:0] wdat, rdat;
	logic [1:0] src, blim;
	logic [2:0] ph, sag, term;
	logic [12:0] fmv;
	logic aux_v = 1'b0, bus_v = 1'b0, short_b = 1'b1, weak_b = 1'b1, fault = 1'b0;
	logic [2:0] fcode = 3'h0;
	logic flt_b = 1'b0, term_b = 1'b0;
	int n_mismatch = 0, total_checks = 0, cycles = 0;

	dsc_host_model host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
		.wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_ack_i(ack), .wb_dat_i(rdat));
	dsc_charge_ctrl #(.UNATT_CYCLES(40'h258), .WDOG_CYCLES(40'h190)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.aux_valid_i(aux_v), .bus_valid_i(bus_v), .bat_below_short_i(short_b),
		.bat_below_weak_i(weak_b), .bat_below_recharge_i(1'b0), .bat_at_float_i(flt_b),
		.term_current_i(term_b), .sag_active_i(1'b0), .boost_on_i(1'b0), .fault_i(fault),
		.fault_code_i(fcode), .selected_charge_source_o(src), .precharge_o(pre),
		.switcher_on_o(sw), .phase_o(ph), .float_mv_o(fmv), .charge_current_code_o(ccc),
		.low_current_limit_o(lowi), .bus_limit_en_o(blen), .bus_input_limit_code_o(blim),
		.sag_voltage_code_o(sag), .termination_current_code_o(term), .unattended_o(unatt),
		.irq_o(irq));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a);
		host.xfer(1'b0, a, 8'h00, q);
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task tally_and_finish;
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task t_reset;
		rd(8'h0c);
		check(q, CHIP_ID);
		check({lowi, unatt}, 2'h3);
		check(fmv, VF_BASE_MV + VF_STEP_MV * 13'h002);
	endtask
	task t_precharge;
		bus_v <= 1'b1;
		wait_n(8);
		check(src, 2'h1);
		check({pre, sw, ph}, {2'h2, 3'h1});
		short_b <= 1'b0;
		weak_b <= 1'b0;
		wait_n(6);
		check({pre, sw, ph}, {2'h1, 3'h2});
	endtask
	task t_banks;
		wr(8'h08, 8'h8c);
		wr(8'h10, 8'h36);
		wr(8'h14, 8'h05);
		wr(8'h04, 8'h88);
		wr(8'h48, 8'hc0);
		wait_n(4);
		check(fmv, VF_BASE_MV + VF_STEP_MV * 13'h023);
		check({lowi, ccc, term, sag}, {1'b0, 4'h3, 3'h6, 3'h5});
		check({blen, blim}, 3'h6);
		rd(8'h04);
		check(q[TE_BIT], 1'b1);
	endtask
	task t_fault;
		fcode <= 3'h3;
		fault <= 1'b1;
		wait_n(6);
		fault <= 1'b0;
		rd(8'h00);
		check(q[2:0], 3'h3);
		rd(8'h40);
		check(q[2:0], 3'h0);
	endtask
	task t_term;
		flt_b <= 1'b1;
		wr(8'h04, 8'h80);
		term_b <= 1'b1;
		wait_n(6);
		check(ph, 3'h3);
		wr(8'h04, 8'h88);
		wait_n(4);
		check(ph, 3'h4);
		flt_b <= 1'b0;
		term_b <= 1'b0;
	endtask
	task t_aux;
		wr(8'h80, 8'h1f);
		wr(8'h44, 8'h02);
		aux_v <= 1'b1;
		wait_n(8);
		check(ph, 3'h0);
		wr(8'h44, 8'h00);
		wait_n(4);
		check({src, ph !== 3'h0}, 3'h5);
		check({fmv, blen}, {VF_BASE_MV + VF_STEP_MV * 13'h02f, 1'b0});
		wr(8'h50, 8'h78);
		rd(8'h50);
		check(q[6:3], AUX_CHARGE_CURRENT_CODE_MAX);
		rd(8'h80);
		check(q[IRQ_SRC], 1'b1);
		wr(8'h84, 8'h1f);
		wait_n(2);
		qa = irq;
		wr(8'h84, 8'h00);
		wait_n(2);
		check(qa, 1'b1);
		check(irq, 1'b0);
		wr(8'h80, 8'h1f);
		rd(8'h80);
		check({q[4:0], irq}, 6'h00);
	endtask
	task t_wdog;
		wait_n(430);
		rd(8'h40);
		check(q[2:0], FAULT_TIMER);
		rd(8'h48);
		check(q, VF_RST);
		rd(8'h08);
		check({q, unatt}, 9'h119);
		rd(8'h88);
		check(q, 8'ha4);
	endtask
	task t_unatt;
		wait_n(620);
		rd(8'h04);
		check(q[CE_BIT], 1'b1);
		rd(8'h44);
		check(q[CE_BIT], 1'b1);
		weak_b <= 1'b1;
		bus_v <= 1'b0;
		wait_n(8);
		bus_v <= 1'b1;
		wait_n(8);
		rd(8'h04);
		check({q[CE_BIT], ph}, 4'h8);
		rd(8'h44);
		check(q[CE_BIT], 1'b1);
		aux_v <= 1'b0;
		bus_v <= 1'b0;
		wait_n(8);
		bus_v <= 1'b1;
		wait_n(8);
		rd(8'h04);
		check({q[CE_BIT], ph}, 4'h2);
	endtask

	initial begin
		wait_n(20);
		rst_i <= 1'b0;
		wait_n(1);
		t_reset();
		t_precharge();
		t_banks();
		t_fault();
		t_term();
		t_aux();
		t_wdog();
		t_unatt();
		tally_and_finish();
	end
endmodule

bind dsc_charge_ctrl dsc_charge_ctrl_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.aux_valid_i(aux_valid_i), .bus_valid_i(bus_valid_i),
	.selected_charge_source_o(selected_charge_source_o), .precharge_o(precharge_o),
	.switcher_on_o(switcher_on_o), .phase_o(phase_o), .float_mv_o(float_mv_o),
	.charge_current_code_o(charge_current_code_o), .low_current_limit_o(low_current_limit_o),
	.bus_limit_en_o(bus_limit_en_o));
